// [hsg_pkg.sv]
// Constants, register map and types for the haptic signal generator.
// Assumes a 40 MHz core clock and a register port in the same domain.
package hsg_pkg;

	// ****************************************************
	// Register map
	// ****************************************************
	localparam logic [15:0] HSG_ADDR_CTRL = 16'h0090;
	localparam logic [15:0] HSG_ADDR_PERIOD = 16'h0091;
	localparam logic [15:0] HSG_ADDR_P1_LVL = 16'h0092;
	localparam logic [15:0] HSG_ADDR_P1_LEN = 16'h0093;
	localparam logic [15:0] HSG_ADDR_P2_LVL = 16'h0094;
	localparam logic [15:0] HSG_ADDR_P2_LEN = 16'h0095;
	localparam logic [15:0] HSG_ADDR_P3_LVL = 16'h0096;
	localparam logic [15:0] HSG_ADDR_P3_LEN = 16'h0097;
	localparam logic [15:0] HSG_ADDR_STATUS = 16'h0098;

	// Field positions in the control register
	localparam int HSG_TRIG_BIT = 4;
	localparam int HSG_MODE_HI = 3;
	localparam int HSG_MODE_LO = 2;
	localparam int HSG_ACT_BIT = 1;
	localparam int HSG_STS_BIT = 0;

	// Field widths
	localparam int HSG_PERIOD_W = 15;
	localparam int HSG_LVL_W = 8;
	localparam int HSG_SHORT_LEN_W = 9;
	localparam int HSG_LONG_LEN_W = 11;
	localparam int HSG_SMP_W = 24;
	localparam int HSG_RATE_W = 5;

	// Reset values
	localparam logic [14:0] HSG_PERIOD_RST = 15'h7fff;
	localparam logic [7:0] HSG_LVL_RST = 8'h00;
	localparam logic [10:0] HSG_LEN_RST = 11'h000;

	// Mode codes of the generator control field
	localparam logic [1:0] HSG_MODE_OFF = 2'h0;
	localparam logic [1:0] HSG_MODE_CONT = 2'h1;
	localparam logic [1:0] HSG_MODE_SHOT = 2'h2;

	// Mixer source code that picks this generator
	localparam logic [7:0] HSG_MIX_SRC = 8'h06;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam int HSG_CLK_PS = 25000;
	localparam int HSG_UNIT_PS = 625000;
	// Fractional divider, in units of 100 Hz
	localparam logic [18:0] HSG_DIV_MOD = 19'h61a80;
	localparam logic [18:0] HSG_DIV_INC_48K = 19'h0f000;
	localparam logic [18:0] HSG_DIV_INC_44K = 19'h0dc80;

	// One-shot profile states
	typedef enum logic [1:0] {
		HSG_IDLE = 2'b00,
		HSG_PH1 = 2'b01,
		HSG_PH2 = 2'b10,
		HSG_PH3 = 2'b11
	} hsg_state_t;

endpackage

// [hsg_fifo2.sv]
// Two-entry sample buffer with valid/ready on both sides.
// Assumes both sides run on the same clock as the generator.
`timescale 1ns/1ps
module hsg_fifo2 #(
	parameter int WIDTH = 24
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic in_valid, // Producer has a word
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Consumer takes word
	output logic [WIDTH-1:0] out_data // Word out, from storage
);

	// ****************************************************
	// Storage and pointers
	// ****************************************************
	logic [WIDTH-1:0] mem_ff [2];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] count_ff;
	logic push;
	logic pop;

	// Handshake terms are combinational by design
	assign in_ready = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign out_data = mem_ff[rd_ptr_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Write side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= 1'b0;
		end else if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
			wr_ptr_ff <= ~wr_ptr_ff;
		end
	end

	// Read side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_ptr_ff <= 1'b0;
		end else if (pop) begin
			rd_ptr_ff <= ~rd_ptr_ff;
		end
	end

	// Occupancy, so full and empty are exact
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_ff <= 2'h0;
		end else if (push && !pop) begin
			count_ff <= count_ff + 2'h1;
		end else if (pop && !push) begin
			count_ff <= count_ff - 2'h1;
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!rst_n)
		(count_ff == 2'h2 && !pop) |=> (count_ff == 2'h2))
		else $error("buffer lost or gained a word while full");

endmodule

// [hsg_top.sv]
// Haptic signal generator: rotating mass DC level or resonant AC output,
// continuous or three-phase one-shot, feeding an output mixer input.
// Assumes register port, sample strobe and mixer select share clk.
`timescale 1ns/1ps
// Contract
// - Mixer source code 0x06 takes our stream
// - Mode field 3:2 picks off/continuous/one-shot
// - Samples produced at the selected rate
// - Bit 1 selects rotating mass or resonant
// - Resonant frequency is clock over 2(N+1)
// - Divider clock is 6.144 or 5.6448 MHz
// - Period ignored for rotating mass actuator
// - Trigger write starts phases one two three
// - Each phase has own length and level
// - Continuous mode uses middle phase level only
// - Rotating mass gives signed DC level
// - Resonant gives AC, negative level inverts
// - Lengths count 0.625 us units, zero skips; the default unit is 625000 ps / 25000 ps = 25 clocks, 0.625 us
// - Levels are 8-bit two's complement
// - Status bit high while profile runs
module hsg_top #(
	parameter int UNIT_CYCLES = hsg_pkg::HSG_UNIT_PS / hsg_pkg::HSG_CLK_PS
) (
	input wire logic clk, // 40 MHz core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [15:0] reg_addr, // Register address
	input wire logic [15:0] reg_wdata, // Write data
	output logic [15:0] reg_rdata, // Read data, one cycle later
	input wire logic clock_family, // 0: 6.144 MHz, 1: 5.6448 MHz
	input wire logic [4:0] generator_sample_rate, // Rate code
	input wire logic sample_strobe, // One pulse per sample period
	input wire logic [7:0] mixer_source_select, // Mixer source code
	output logic mix_valid, // Sample offered to mixer
	input wire logic mix_ready, // Mixer takes sample
	output logic [23:0] mix_data, // Signed sample
	output logic [4:0] mix_rate, // Rate of offered sample
	output logic profile_in_progress // One-shot running
);

	// ****************************************************
	// Registers
	// ****************************************************
	logic [1:0] mode_ff;
	logic act_ff;
	logic [14:0] period_ff;
	logic [7:0] lvl1_ff;
	logic [7:0] lvl2_ff;
	logic [7:0] lvl3_ff;
	logic [10:0] len1_ff;
	logic [10:0] len2_ff;
	logic [10:0] len3_ff;
	logic ctl_wr;
	logic trig_wr;

	assign ctl_wr = reg_wr && (reg_addr == hsg_pkg::HSG_ADDR_CTRL);
	// Trigger honoured only when the new mode is one-shot
	assign trig_wr = ctl_wr && reg_wdata[hsg_pkg::HSG_TRIG_BIT] &&
		(reg_wdata[hsg_pkg::HSG_MODE_HI:hsg_pkg::HSG_MODE_LO] ==
		hsg_pkg::HSG_MODE_SHOT);

	// Control and setting registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_ff <= hsg_pkg::HSG_MODE_OFF;
			act_ff <= 1'b0;
			period_ff <= hsg_pkg::HSG_PERIOD_RST;
			lvl1_ff <= hsg_pkg::HSG_LVL_RST;
			lvl2_ff <= hsg_pkg::HSG_LVL_RST;
			lvl3_ff <= hsg_pkg::HSG_LVL_RST;
			len1_ff <= hsg_pkg::HSG_LEN_RST;
			len2_ff <= hsg_pkg::HSG_LEN_RST;
			len3_ff <= hsg_pkg::HSG_LEN_RST;
		end else if (reg_wr) begin
			if (reg_addr == hsg_pkg::HSG_ADDR_CTRL) begin
				mode_ff <= reg_wdata[hsg_pkg::HSG_MODE_HI:
					hsg_pkg::HSG_MODE_LO];
				act_ff <= reg_wdata[hsg_pkg::HSG_ACT_BIT];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_PERIOD) begin
				period_ff <= reg_wdata[hsg_pkg::HSG_PERIOD_W-1:0];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P1_LVL) begin
				lvl1_ff <= reg_wdata[hsg_pkg::HSG_LVL_W-1:0];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P1_LEN) begin
				len1_ff <= {2'h0, reg_wdata[hsg_pkg::HSG_SHORT_LEN_W-1:0]};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P2_LVL) begin
				lvl2_ff <= reg_wdata[hsg_pkg::HSG_LVL_W-1:0];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P2_LEN) begin
				len2_ff <= reg_wdata[hsg_pkg::HSG_LONG_LEN_W-1:0];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P3_LVL) begin
				lvl3_ff <= reg_wdata[hsg_pkg::HSG_LVL_W-1:0];
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P3_LEN) begin
				len3_ff <= {2'h0, reg_wdata[hsg_pkg::HSG_SHORT_LEN_W-1:0]};
			end
		end
	end

	// Read port; trigger reads back as zero, unmapped reads zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr == hsg_pkg::HSG_ADDR_CTRL) begin
				reg_rdata <= {12'h000, mode_ff, act_ff, 1'b0};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_PERIOD) begin
				reg_rdata <= {1'b0, period_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P1_LVL) begin
				reg_rdata <= {8'h00, lvl1_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P1_LEN) begin
				reg_rdata <= {5'h00, len1_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P2_LVL) begin
				reg_rdata <= {8'h00, lvl2_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P2_LEN) begin
				reg_rdata <= {5'h00, len2_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P3_LVL) begin
				reg_rdata <= {8'h00, lvl3_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_P3_LEN) begin
				reg_rdata <= {5'h00, len3_ff};
			end else if (reg_addr == hsg_pkg::HSG_ADDR_STATUS) begin
				reg_rdata <= {15'h0000, profile_in_progress};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	// ****************************************************
	// Divided system clock and resonant half period
	// ****************************************************
	logic [18:0] acc_ff;
	logic [18:0] acc_sum;
	logic div_tick;
	logic [14:0] half_cnt_ff;
	logic pol_ff;

	// Phase accumulator keeps the long-run rate exact, at the cost of
	// a small jitter on each tick
	assign acc_sum = acc_ff + (clock_family ? hsg_pkg::HSG_DIV_INC_44K :
		hsg_pkg::HSG_DIV_INC_48K);
	assign div_tick = (acc_sum >= hsg_pkg::HSG_DIV_MOD);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_ff <= 19'h00000;
		end else if (div_tick) begin
			acc_ff <= acc_sum - hsg_pkg::HSG_DIV_MOD;
		end else begin
			acc_ff <= acc_sum;
		end
	end

	// Toggle every period+1 ticks, giving clock / (2 * (period + 1))
	always_ff @(posedge clk) begin
		if (!rst_n || mode_ff == hsg_pkg::HSG_MODE_OFF) begin
			half_cnt_ff <= 15'h0000;
			pol_ff <= 1'b0;
		end else if (div_tick) begin
			if (half_cnt_ff >= period_ff) begin
				half_cnt_ff <= 15'h0000;
				pol_ff <= ~pol_ff;
			end else begin
				half_cnt_ff <= half_cnt_ff + 15'h0001;
			end
		end
	end

	// ****************************************************
	// One-shot profile
	// ****************************************************
	hsg_pkg::hsg_state_t state_ff;
	logic [15:0] unit_cnt_ff;
	logic [10:0] ph_cnt_ff;
	logic [10:0] cur_len;
	logic ph_done;
	logic unit_tick;

	always_comb begin
		case (state_ff)
			hsg_pkg::HSG_PH1: cur_len = len1_ff;
			hsg_pkg::HSG_PH2: cur_len = len2_ff;
			hsg_pkg::HSG_PH3: cur_len = len3_ff;
			default: cur_len = 11'h000;
		endcase
	end

	// A zero length ends the phase at once
	assign ph_done = (ph_cnt_ff == cur_len);
	assign unit_tick = (unit_cnt_ff == 16'(UNIT_CYCLES - 1));

	// Phase sequencer; a new trigger restarts from phase one. The trigger
	// write carries the one-shot mode itself, so it beats the old mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= hsg_pkg::HSG_IDLE;
		end else if (trig_wr) begin
			state_ff <= hsg_pkg::HSG_PH1;
		end else if (mode_ff != hsg_pkg::HSG_MODE_SHOT) begin
			state_ff <= hsg_pkg::HSG_IDLE;
		end else if (ph_done) begin
			case (state_ff)
				hsg_pkg::HSG_PH1: state_ff <= hsg_pkg::HSG_PH2;
				hsg_pkg::HSG_PH2: state_ff <= hsg_pkg::HSG_PH3;
				default: state_ff <= hsg_pkg::HSG_IDLE;
			endcase
		end
	end

	// 0.625 us unit timer (UNIT_CYCLES clocks) and per-phase unit count
	always_ff @(posedge clk) begin
		if (!rst_n || trig_wr || ph_done) begin
			unit_cnt_ff <= 16'h0000;
			ph_cnt_ff <= 11'h000;
		end else if (unit_tick) begin
			unit_cnt_ff <= 16'h0000;
			ph_cnt_ff <= ph_cnt_ff + 11'h001;
		end else begin
			unit_cnt_ff <= unit_cnt_ff + 16'h0001;
		end
	end

	assign profile_in_progress = (state_ff != hsg_pkg::HSG_IDLE);

	// ****************************************************
	// Sample formation and buffering
	// ****************************************************
	logic [7:0] act_lvl;
	logic [23:0] dc_smp;
	logic [23:0] smp_ff;
	logic gen_vld_ff;
	logic buf_ready;
	logic buf_out_valid;
	logic routed;

	// Active intensity; continuous uses only the middle phase level
	always_comb begin
		act_lvl = hsg_pkg::HSG_LVL_RST;
		if (mode_ff == hsg_pkg::HSG_MODE_CONT) begin
			act_lvl = lvl2_ff;
		end else if (mode_ff == hsg_pkg::HSG_MODE_SHOT) begin
			case (state_ff)
				hsg_pkg::HSG_PH1: act_lvl = lvl1_ff;
				hsg_pkg::HSG_PH2: act_lvl = lvl2_ff;
				hsg_pkg::HSG_PH3: act_lvl = lvl3_ff;
				default: act_lvl = hsg_pkg::HSG_LVL_RST;
			endcase
		end
	end

	assign dc_smp = {act_lvl, 16'h0000};

	// Inversion is one's complement: no overflow at full negative scale,
	// error is one LSB of 24 bits
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			smp_ff <= 24'h000000;
		end else if (sample_strobe) begin
			if (act_lvl == hsg_pkg::HSG_LVL_RST) begin
				smp_ff <= 24'h000000;
			end else if (act_ff && pol_ff) begin
				smp_ff <= ~dc_smp;
			end else begin
				smp_ff <= dc_smp;
			end
		end
	end

	// One sample per rate strobe; a stalled sample is replaced by newer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gen_vld_ff <= 1'b0;
		end else if (sample_strobe) begin
			gen_vld_ff <= 1'b1;
		end else if (buf_ready) begin
			gen_vld_ff <= 1'b0;
		end
	end

	// Unrouted output drains so stale samples never pile up
	assign routed = (mixer_source_select == hsg_pkg::HSG_MIX_SRC);
	assign mix_valid = buf_out_valid && routed;
	assign mix_rate = generator_sample_rate;

	hsg_fifo2 #(
		.WIDTH(hsg_pkg::HSG_SMP_W)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(gen_vld_ff),
		.in_ready(buf_ready),
		.in_data(smp_ff),
		.out_valid(buf_out_valid),
		.out_ready(mix_ready || !routed),
		.out_data(mix_data)
	);

	// ****************************************************
	// Checks
	// ****************************************************
	a_mixer_route: assert property (@(posedge clk) disable iff (!rst_n)
		mix_valid |-> (mixer_source_select == hsg_pkg::HSG_MIX_SRC))
		else $error("sample offered to a mixer not selecting us");
	a_off_no_profile: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_ff == hsg_pkg::HSG_MODE_OFF && !trig_wr) |=>
		!profile_in_progress)
		else $error("profile runs while disabled");
	a_off_zero_sample: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_ff == hsg_pkg::HSG_MODE_OFF && sample_strobe) |=>
		(smp_ff == 24'h000000))
		else $error("nonzero sample while disabled");
	a_trigger_start: assert property (@(posedge clk) disable iff (!rst_n)
		trig_wr |=> (state_ff == hsg_pkg::HSG_PH1 && profile_in_progress))
		else $error("trigger did not start phase one");
	a_phase_order: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == hsg_pkg::HSG_PH1 && ph_done && !ctl_wr &&
		mode_ff == hsg_pkg::HSG_MODE_SHOT) |=>
		(state_ff == hsg_pkg::HSG_PH2))
		else $error("phase one did not pass to phase two");
	a_profile_end: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == hsg_pkg::HSG_PH3 && ph_done && !ctl_wr &&
		mode_ff == hsg_pkg::HSG_MODE_SHOT) |=>
		(!profile_in_progress && act_lvl == hsg_pkg::HSG_LVL_RST))
		else $error("profile did not end after phase three");
	a_cont_level: assert property (@(posedge clk) disable iff (!rst_n)
		(mode_ff == hsg_pkg::HSG_MODE_CONT) |-> (act_lvl == lvl2_ff))
		else $error("continuous level not from middle phase");
	a_erm_dc_level: assert property (@(posedge clk) disable iff (!rst_n)
		(sample_strobe && !act_ff && act_lvl != hsg_pkg::HSG_LVL_RST) |=>
		(smp_ff == {$past(act_lvl), 16'h0000}))
		else $error("rotating mass sample not the DC level");
	a_lra_invert: assert property (@(posedge clk) disable iff (!rst_n)
		(sample_strobe && act_ff && pol_ff && act_lvl != 8'h00) |=>
		(smp_ff[23] != $past(act_lvl[7])))
		else $error("resonant half cycle not inverted");
	a_half_period: assert property (@(posedge clk) disable iff (!rst_n)
		(div_tick && half_cnt_ff == period_ff &&
		mode_ff != hsg_pkg::HSG_MODE_OFF) |=> (pol_ff != $past(pol_ff)))
		else $error("polarity did not toggle at period end");
	a_div_spacing: assert property (@(posedge clk) disable iff (!rst_n)
		div_tick |=> !div_tick [*5])
		else $error("divided clock faster than its base rate");
	a_rate_strobe: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(gen_vld_ff) |-> $past(sample_strobe))
		else $error("sample produced without a rate strobe");

	c_profile_done: cover property (@(posedge clk) disable iff (!rst_n)
		(state_ff == hsg_pkg::HSG_PH3) ##1 !profile_in_progress);
	c_lra_toggle: cover property (@(posedge clk) disable iff (!rst_n)
		act_ff && $changed(pol_ff));
	c_buf_full: cover property (@(posedge clk) disable iff (!rst_n)
		gen_vld_ff && !buf_ready);
	c_cont_out: cover property (@(posedge clk) disable iff (!rst_n)
		mix_valid && mix_ready && mode_ff == hsg_pkg::HSG_MODE_CONT);

endmodule

// [hsg_mixer_model.sv]
// Output mixer model: selects its source and takes samples with stalls.
// Assumes one clock shared with the generator.
`timescale 1ns/1ps
module hsg_mixer_model (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic route, // Pick the generator as source
	input wire logic hold, // Forces a long stall
	output logic [7:0] src_sel, // Mixer source code
	output logic mix_ready // Sample taken
);
	logic [7:0] lfsr_ff;
	// ****************************************************
	// Source select and stall pattern
	// ****************************************************
	// Random gaps in ready make the buffer hold words, not pass them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lfsr_ff <= 8'h5a;
			mix_ready <= 1'b0;
			src_sel <= 8'h00;
		end else begin
			lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
			mix_ready <= !hold && lfsr_ff[0];
			src_sel <= route ? hsg_pkg::HSG_MIX_SRC : 8'h00;
		end
	end
endmodule

// [haptic_signal_generator_test.sv]
// Self-checking bench for the haptic signal generator.
// Assumes hsg_top with a shortened duration unit and the mixer model.
`timescale 1ns/1ps
module haptic_signal_generator_test;
	localparam int UNIT = 4;
	logic clk, rst_n, reg_wr, reg_rd, clock_family, sample_strobe;
	logic mix_valid, mix_ready, profile_in_progress, route, hold, rd_d;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic [4:0] rate, mix_rate;
	logic [7:0] src, v;
	logic [23:0] mix_data, e;
	logic [31:0] lfsr;
	logic [23:0] sq[$];
	bit lq[$];
	logic [15:0] rq[$];
	bit l;
	int error_cnt, n_checks, inv_cnt, plain_cnt;

	hsg_top #(.UNIT_CYCLES(UNIT)) dut (.clk(clk), .rst_n(rst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.clock_family(clock_family), .generator_sample_rate(rate),
		.sample_strobe(sample_strobe), .mixer_source_select(src),
		.mix_valid(mix_valid), .mix_ready(mix_ready), .mix_data(mix_data),
		.mix_rate(mix_rate), .profile_in_progress(profile_in_progress));
	hsg_mixer_model mixer (.clk(clk), .rst_n(rst_n), .route(route),
		.hold(hold), .src_sel(src), .mix_ready(mix_ready));

	// ****************************************************
	// Compare and report
	// ****************************************************
	task automatic cmp_val(input logic [23:0] x, input logic [23:0] g);
		n_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("wrong value at %0t: expected %h got %h", $time, x, g);
		end
	endtask
	task automatic cmp_bit(input logic x, input logic g);
		cmp_val({23'h0, x}, {23'h0, g});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ****************************************************
	// Drivers
	// ****************************************************
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] x);
		@(posedge clk);
		rq.push_back(x);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic note(input logic [7:0] lv, input bit resonant_linear_actuator);
		sq.push_back({lv, 16'h0000});
		lq.push_back(resonant_linear_actuator);
	endtask
	// Strobes spaced so the buffer never overflows under random stalls
	task automatic smp(input logic [7:0] lv, input bit resonant_linear_actuator);
		@(posedge clk);
		note(lv, resonant_linear_actuator);
		sample_strobe <= 1'b1;
		@(posedge clk);
		sample_strobe <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic rnd;
		lfsr = step(lfsr);
		v = lfsr[7:0] | 8'h01;
	endtask
	// One-shot run; probes one sample inside each phase
	task automatic shot(input logic [10:0] l1, l2, l3, input bit probe);
		int n;
		logic [7:0] lv[3];
		for (int i = 0; i < 3; i++) begin
			rnd;
			lv[i] = (i == 2) ? (v | 8'h80) : v;
			wr(hsg_pkg::HSG_ADDR_P1_LVL + 16'(2 * i), {8'h00, lv[i]});
		end
		wr(hsg_pkg::HSG_ADDR_P1_LEN, {5'h0, l1});
		wr(hsg_pkg::HSG_ADDR_P2_LEN, {5'h0, l2});
		wr(hsg_pkg::HSG_ADDR_P3_LEN, {5'h0, l3});
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0018);
		#1;
		n = 0;
		for (int i = 0; i < 3000; i++) begin
			if (profile_in_progress === 1'b1) n++;
			else if (n > 0) break;
			sample_strobe <= probe && (n == 10 || n == 60 || n == 140);
			if (probe && n == 10) note(lv[0], 0);
			if (probe && n == 60) note(lv[1], 0);
			if (probe && n == 140) note(lv[2], 0);
			@(posedge clk);
			#1;
		end
		sample_strobe <= 1'b0;
		cmp_val(24'((l1 + l2 + l3) * UNIT + 3), 24'(n));
		smp(8'h00, 0);
	endtask

	// ****************************************************
	// Clock, monitor and watchdog
	// ****************************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Oldest note is matched against each accepted sample, oldest queued read value against each read word
	always @(posedge clk) begin
		if (rst_n && mix_valid === 1'b1 && mix_ready === 1'b1) begin
			if (sq.size() == 0) begin
				cmp_bit(1'b0, 1'b1);
			end else begin
				e = sq.pop_front();
				l = lq.pop_front();
				if (l && e != 0 && mix_data === ~e) begin
					inv_cnt++;
					e = ~e;
				end else if (l && e != 0) begin
					plain_cnt++;
				end
				cmp_val(e, mix_data);
			end
		end
		if (rd_d) cmp_val({8'h00, rq.pop_front()}, {8'h00, reg_rdata});
		rd_d <= reg_rd;
	end
	initial begin
		#(25 * 20000);
		error_cnt++;
		tally_and_finish();
	end

	// ****************************************************
	// Main sequence
	// ****************************************************
	initial begin
		// Mode stays off until the clock runs and reset is gone
		rst_n = 1'b0;
		{reg_wr, reg_rd, sample_strobe, clock_family, hold, rd_d} = '0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		rate = 5'h00;
		route = 1'b1;
		lfsr = 32'h87c6aebc;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(hsg_pkg::HSG_ADDR_PERIOD, 16'h7fff);
		rd(hsg_pkg::HSG_ADDR_STATUS, 16'h0000);
		rd(hsg_pkg::HSG_ADDR_CTRL, 16'h0000);
		rd(16'h0099, 16'h0000);
		wr(hsg_pkg::HSG_ADDR_P1_LEN, 16'hffff);
		rd(hsg_pkg::HSG_ADDR_P1_LEN, 16'h01ff);
		wr(hsg_pkg::HSG_ADDR_P2_LEN, 16'hffff);
		rd(hsg_pkg::HSG_ADDR_P2_LEN, 16'h07ff);
		// In-range period first; a short one later keeps the run brief
		wr(hsg_pkg::HSG_ADDR_PERIOD, 16'h2fff);
		rd(hsg_pkg::HSG_ADDR_PERIOD, 16'h2fff);
		// Continuous rotating mass: middle level only, period ignored
		wr(hsg_pkg::HSG_ADDR_PERIOD, 16'h0003);
		for (int i = 0; i < 6; i++) begin
			rnd;
			rate <= lfsr[12:8];
			wr(hsg_pkg::HSG_ADDR_P2_LVL, {8'h00, v});
			wr(hsg_pkg::HSG_ADDR_P1_LVL, {8'h00, ~v});
			if (i == 0) wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0004);
			smp(v, 0);
			cmp_val({19'h0, lfsr[12:8]}, {19'h0, mix_rate});
		end
		// Other source selected: nothing offered to the mixer
		while (sq.size() != 0) @(posedge clk);
		route <= 1'b0;
		repeat (3) @(posedge clk);
		sample_strobe <= 1'b1;
		@(posedge clk);
		sample_strobe <= 1'b0;
		repeat (6) @(posedge clk) cmp_bit(1'b0, mix_valid);
		route <= 1'b1;
		// Mixer stalls while two words wait in the buffer
		hold <= 1'b1;
		repeat (2) begin
			rnd;
			wr(hsg_pkg::HSG_ADDR_P2_LVL, {8'h00, v});
			smp(v, 0);
		end
		repeat (4) @(posedge clk) cmp_bit(1'b1, mix_valid);
		hold <= 1'b0;
		repeat (10) @(posedge clk);
		// Resonant actuator in both clock families
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0006);
		for (int i = 0; i < 32; i++) begin
			clock_family <= i[4];
			rnd;
			wr(hsg_pkg::HSG_ADDR_P2_LVL, {8'h00, v});
			smp(v, 1);
		end
		repeat (10) @(posedge clk);
		cmp_bit(1'b1, inv_cnt > 0);
		cmp_bit(1'b1, plain_cnt > 0);
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0000);
		smp(8'h00, 0);
		// One-shot profiles
		shot(11'h000, 11'h000, 11'h000, 0);
		shot(11'h00a, 11'h014, 11'h00a, 1);
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0018);
		rd(hsg_pkg::HSG_ADDR_STATUS, 16'h0001);
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0000);
		@(posedge clk);
		#1;
		cmp_bit(1'b0, profile_in_progress);
		wr(hsg_pkg::HSG_ADDR_CTRL, 16'h0010);
		repeat (2) @(posedge clk);
		#1;
		cmp_bit(1'b0, profile_in_progress);
		repeat (20) @(posedge clk);
		cmp_val(24'h0, 24'(sq.size()));
		tally_and_finish();
	end
endmodule
